// ===== mqu_pkg.sv
// Package of offsets, field positions and reset values for the message queue unit
package mqu_pkg;
   localparam logic [7:0]  HOST_STATUS_OFS  = 8'h30;
   localparam logic [7:0]  HOST_MASK_OFS    = 8'h34;
   localparam logic [7:0]  LOCAL_STATUS_OFS = 8'h38;
   localparam logic [7:0]  LOCAL_MASK_OFS   = 8'h3C;
   localparam logic [7:0]  PORT_IFREE_OFS   = 8'h40;
   localparam logic [7:0]  PORT_OPOST_OFS   = 8'h44;
   localparam logic [7:0]  PORT_IPOST_OFS   = 8'h48;
   localparam logic [7:0]  PORT_OFREE_OFS   = 8'h4C;
   localparam int          MASK_BIT         = 3;
   localparam int          NOT_EMPTY_BIT    = 3;
   localparam logic [31:0] MASK_RESET       = 32'hFFFFFFFF;
   localparam logic [31:0] EMPTY_READ       = 32'hFFFFFFFF;
   localparam int          QUEUE_DEPTH      = 32;
   localparam int          QUEUE_WIDTH      = 32;
   // Queue indices
   localparam int          Q_IFREE          = 0;
   localparam int          Q_IPOST          = 1;
   localparam int          Q_OPOST          = 2;
   localparam int          Q_OFREE          = 3;
endpackage

// ===== mqu_queue.sv
// One message queue: synchronous FIFO with flush, drop-on-full and all-ones empty read
`timescale 1ns/1ps
module mqu_queue #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic                  not_empty
);
   localparam int AW = $clog2(DEPTH);
   // Pointers wrap freely, so only power-of-two depths keep every pointer value inside mem
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1 || WIDTH > 32) begin : g_bad_params
      $error("mqu_queue: DEPTH must be a power of two, WIDTH 1 to 32");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             full;
   logic             do_push;
   logic             do_pop;
   assign full      = (count == (AW+1)'(DEPTH)); // [R16]
   assign not_empty = (count != '0);
   assign do_push   = push && !full; // [R11]
   assign do_pop    = pop && not_empty; // [R10]
   // Empty queue answers all ones
   assign head      = not_empty ? mem[rd_ptr] : mqu_pkg::EMPTY_READ[WIDTH-1:0]; // [R10]
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data; // [R15]
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ptr <= '0; // [R12] [R13]
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) wr_ptr <= wr_ptr + 1'b1; // [R15]
         if (do_pop) rd_ptr <= rd_ptr + 1'b1; // [R15]
         if (do_push && !do_pop) count <= count + 1'b1;
         else if (do_pop && !do_push) count <= count - 1'b1;
      end
   end
endmodule

// ===== mqu_mask_reg.sv
// Interrupt mask register whose unused bits read as ones
`timescale 1ns/1ps
module mqu_mask_reg (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   output logic             masked,
   output logic      [31:0] rd_value
);
   always_ff @(posedge sys_clk) begin
      if (srst) masked <= mqu_pkg::MASK_RESET[mqu_pkg::MASK_BIT]; // [R3] [R4]
      else if (wr_en) masked <= wr_data[mqu_pkg::MASK_BIT];
   end
   always_comb begin
      rd_value = mqu_pkg::MASK_RESET; // [R5]
      rd_value[mqu_pkg::MASK_BIT] = masked;
   end
endmodule

// ===== mqu_unit.sv
// Message queue unit: four queues, status, masks and interrupt requests
// Behaviour
// [R1] Host status bit shows outbound post queue not empty; reads 0 after reset.
// [R2] Local status bit shows inbound post queue not empty; reads 0 after reset.
// [R3] Host mask bit 3 blocks host interrupt when set; resets set.
// [R4] Local mask bit 3 blocks local interrupt when set; resets set.
// [R5] Unused bits of both mask registers read as one.
// [R6] Port 0x40: read pops inbound free, write pushes inbound post.
// [R7] Port 0x44: read pops outbound post, write pushes outbound free.
// [R8] Port 0x48: read pops inbound post, write pushes inbound free.
// [R9] Port 0x4C: read pops outbound free, write pushes outbound post.
// [R10] Read of an empty queue returns all ones, queue unchanged.
// [R11] Write to a full queue is discarded, contents unchanged.
// [R12] Every queue starts empty.
// [R13] Reset flushes all four queues.
// [R14] Interrupt requested while matching post queue not empty and unmasked.
// [R15] Each read removes one entry in FIFO order; each accepted write adds one.
// [R16] Each queue holds 32 entries of 32 bits.
`timescale 1ns/1ps
module mqu_unit #(
   parameter int DEPTH = mqu_pkg::QUEUE_DEPTH
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             reg_rvalid,
   output logic             host_irq,
   output logic             local_irq
);
   localparam int W = mqu_pkg::QUEUE_WIDTH;
   logic [3:0]   push;
   logic [3:0]   pop;
   logic [W-1:0] head [4];
   logic [3:0]   not_empty;
   logic         host_masked;
   logic         local_masked;
   logic [31:0]  host_mask_value;
   logic [31:0]  local_mask_value;
   logic [31:0]  next_rdata;

   // Port decode: each port pops one queue and pushes another
   always_comb begin
      push = '0;
      pop  = '0;
      case (reg_addr)
         mqu_pkg::PORT_IFREE_OFS: begin
            pop[mqu_pkg::Q_IFREE]  = reg_rd; // [R6]
            push[mqu_pkg::Q_IPOST] = reg_wr; // [R6]
         end
         mqu_pkg::PORT_OPOST_OFS: begin
            pop[mqu_pkg::Q_OPOST]  = reg_rd; // [R7]
            push[mqu_pkg::Q_OFREE] = reg_wr; // [R7]
         end
         mqu_pkg::PORT_IPOST_OFS: begin
            pop[mqu_pkg::Q_IPOST]  = reg_rd; // [R8]
            push[mqu_pkg::Q_IFREE] = reg_wr; // [R8]
         end
         mqu_pkg::PORT_OFREE_OFS: begin
            pop[mqu_pkg::Q_OFREE]  = reg_rd; // [R9]
            push[mqu_pkg::Q_OPOST] = reg_wr; // [R9]
         end
         default: begin
            push = '0;
            pop  = '0;
         end
      endcase
   end

   genvar q;
   generate
      for (q = 0; q < 4; q++) begin : g_queue
         mqu_queue #(
            .WIDTH (W),
            .DEPTH (DEPTH)
         ) u_queue (
            .sys_clk   (sys_clk),
            .srst      (srst),
            .push      (push[q]),
            .push_data (reg_wdata),
            .pop       (pop[q]),
            .head      (head[q]),
            .not_empty (not_empty[q])
         );
      end
   endgenerate

   mqu_mask_reg u_host_mask (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .wr_en    (reg_wr && reg_addr == mqu_pkg::HOST_MASK_OFS),
      .wr_data  (reg_wdata),
      .masked   (host_masked),
      .rd_value (host_mask_value)
   );

   mqu_mask_reg u_local_mask (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .wr_en    (reg_wr && reg_addr == mqu_pkg::LOCAL_MASK_OFS),
      .wr_data  (reg_wdata),
      .masked   (local_masked),
      .rd_value (local_mask_value)
   );

   // Read mux; data is sampled before the pop takes effect
   always_comb begin
      next_rdata = '0;
      case (reg_addr)
         mqu_pkg::HOST_STATUS_OFS:  next_rdata[mqu_pkg::NOT_EMPTY_BIT] = not_empty[mqu_pkg::Q_OPOST]; // [R1]
         mqu_pkg::LOCAL_STATUS_OFS: next_rdata[mqu_pkg::NOT_EMPTY_BIT] = not_empty[mqu_pkg::Q_IPOST]; // [R2]
         mqu_pkg::HOST_MASK_OFS:    next_rdata = host_mask_value; // [R5]
         mqu_pkg::LOCAL_MASK_OFS:   next_rdata = local_mask_value; // [R5]
         mqu_pkg::PORT_IFREE_OFS:   next_rdata = head[mqu_pkg::Q_IFREE];
         mqu_pkg::PORT_OPOST_OFS:   next_rdata = head[mqu_pkg::Q_OPOST];
         mqu_pkg::PORT_IPOST_OFS:   next_rdata = head[mqu_pkg::Q_IPOST];
         mqu_pkg::PORT_OFREE_OFS:   next_rdata = head[mqu_pkg::Q_OFREE];
         default:                   next_rdata = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) reg_rdata <= next_rdata;
      end
   end

   // Registered so outputs come from flops; one cycle behind status
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         host_irq  <= 1'b0;
         local_irq <= 1'b0;
      end else begin
         host_irq  <= not_empty[mqu_pkg::Q_OPOST] && !host_masked; // [R14] [R3]
         local_irq <= not_empty[mqu_pkg::Q_IPOST] && !local_masked; // [R14] [R4]
      end
   end
endmodule

// ===== mqu_props.sv
// Checker of the message queue unit port relations
`timescale 1ns/1ps
module mqu_props (
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic        reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        host_irq,
   input wire logic        local_irq
);
   // Mask set, then left alone for a cycle
   sequence s_mask_set(logic [7:0] a);
      reg_wr && reg_addr == a && reg_wdata[mqu_pkg::MASK_BIT] ##1 !(reg_wr && reg_addr == a);
   endsequence
   a_read_answered: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd |=> reg_rvalid) else $error("read not answered");
   a_no_spurious_answer: assert property (@(posedge sys_clk) disable iff (srst)
      !reg_rd |=> !reg_rvalid) else $error("answer without read");
   a_reset_quiet: assert property (@(posedge sys_clk)
      srst |=> !reg_rvalid && !host_irq && !local_irq) else $error("outputs up in reset");
   a_mask_unused_ones: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && (reg_addr == mqu_pkg::HOST_MASK_OFS || reg_addr == mqu_pkg::LOCAL_MASK_OFS)
      |=> reg_rdata[31:4] == 28'hFFFFFFF && reg_rdata[2:0] == 3'h7)
      else $error("mask unused bits not ones");
   a_host_masked: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rvalid && $past(reg_addr) == mqu_pkg::HOST_MASK_OFS
      && reg_rdata[mqu_pkg::MASK_BIT] |-> !host_irq)
      else $error("host irq while masked");
   a_local_masked: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rvalid && $past(reg_addr) == mqu_pkg::LOCAL_MASK_OFS
      && reg_rdata[mqu_pkg::MASK_BIT] |-> !local_irq)
      else $error("local irq while masked");
   a_host_mask_drop: assert property (@(posedge sys_clk) disable iff (srst)
      s_mask_set(mqu_pkg::HOST_MASK_OFS) |=> !host_irq) else $error("host irq not dropped");
   a_local_mask_drop: assert property (@(posedge sys_clk) disable iff (srst)
      s_mask_set(mqu_pkg::LOCAL_MASK_OFS) |=> !local_irq) else $error("local irq not dropped");
endmodule
bind mqu_unit mqu_props u_props (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .host_irq(host_irq), .local_irq(local_irq));

// ===== mqu_host.sv
// Bus master model of the host and local processor side
`timescale 1ns/1ps
module mqu_host (
   input  wire logic        sys_clk,
   output logic      [7:0]  reg_addr,
   output logic             reg_rd,
   output logic             reg_wr,
   output logic      [31:0] reg_wdata,
   input  wire logic [31:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   initial {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
   task automatic release_bus;
      reg_rd = 1'h0;
      reg_wr = 1'h0;
      reg_addr = ~reg_addr;  // Stale lines must not pass as valid
      reg_wdata = ~reg_wdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'h1;
      @(negedge sys_clk);
      release_bus();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge sys_clk);
      release_bus();
      v = reg_rvalid ? reg_rdata : 32'hX;
   endtask
endmodule

// ===== testbench.sv
// Self-checking bench of the message queue unit
`timescale 1ns/1ps
module testbench;
   // Full documented depth, so the full-queue drop is seen at the real size
   localparam int DEPTH = mqu_pkg::QUEUE_DEPTH;
   localparam int RDQ[4] = '{mqu_pkg::Q_IFREE, mqu_pkg::Q_OPOST, mqu_pkg::Q_IPOST, mqu_pkg::Q_OFREE};
   localparam int WRQ[4] = '{mqu_pkg::Q_IPOST, mqu_pkg::Q_OFREE, mqu_pkg::Q_IFREE, mqu_pkg::Q_OPOST};
   logic        sys_clk;
   logic        srst;
   logic [7:0]  reg_addr;
   logic        reg_rd;
   logic        reg_wr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   logic        host_irq;
   logic        local_irq;
   logic [31:0] q[4][$];
   logic [31:0] d;
   bit          um;
   int          err_total;
   int          checks;
   int          cyc;
   mqu_unit #(.DEPTH(DEPTH)) u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .host_irq(host_irq), .local_irq(local_irq));
   mqu_host u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] pop_exp(input int p);
      if (q[RDQ[p]].size() == 0) return mqu_pkg::EMPTY_READ;
      return q[RDQ[p]].pop_front();
   endfunction
   task automatic port_op(input int p, input bit w);
      d = $urandom;
      if (w) begin
         u_host.wr(mqu_pkg::PORT_IFREE_OFS + 8'(4 * p), d);
         if (q[WRQ[p]].size() < DEPTH) q[WRQ[p]].push_back(d);
      end else begin
         u_host.rd(mqu_pkg::PORT_IFREE_OFS + 8'(4 * p), d);
         chk(d, pop_exp(p));
      end
   endtask
   task automatic chk_stat;
      u_host.rd(mqu_pkg::HOST_STATUS_OFS, d);
      chk(d, {28'h0, q[mqu_pkg::Q_OPOST].size() != 0, 3'h0});
      u_host.rd(mqu_pkg::LOCAL_STATUS_OFS, d);
      chk(d, {28'h0, q[mqu_pkg::Q_IPOST].size() != 0, 3'h0});
      chk({30'h0, host_irq, local_irq}, {30'h0, um && q[mqu_pkg::Q_OPOST].size() != 0,
          um && q[mqu_pkg::Q_IPOST].size() != 0});
   endtask
   task automatic set_masks(input logic [31:0] v);
      for (int i = 0; i < 2; i++) begin
         u_host.wr(mqu_pkg::HOST_MASK_OFS + 8'(8 * i), v);
         u_host.rd(mqu_pkg::HOST_MASK_OFS + 8'(8 * i), d);
         chk(d, v | 32'hFFFFFFF7);
      end
   endtask
   task automatic stop_test;
      $display("Mismatches %0d, checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'h0BD72ED9));
      srst = 1'h1;
      repeat (11) @(negedge sys_clk);
      srst = 1'h0;
      for (int i = 0; i < 4; i++) port_op(i, 0);
      set_masks(mqu_pkg::MASK_RESET);
      for (int i = 0; i < 400; i++) begin
         if (i == 200) um = 1'h1;
         if (i == 200) set_masks(32'h0);
         port_op($urandom_range(3), $urandom_range(99) < 55);
         chk_stat();
      end
      // Overfill every queue, then drain two past empty
      for (int i = 0; i < 4 * (DEPTH + 2); i++) port_op(i % 4, 1);
      for (int i = 0; i < 4 * (DEPTH + 2); i++) port_op(i % 4, 0);
      for (int i = 0; i < 8; i++) port_op(i % 4, 1);
      chk_stat();
      um = 1'h0;
      set_masks(mqu_pkg::MASK_RESET);
      chk_stat();
      srst = 1'h1;
      repeat (2) @(negedge sys_clk);
      srst = 1'h0;
      foreach (q[i]) q[i].delete();
      for (int i = 0; i < 4; i++) port_op(i, 0);
      chk_stat();
      stop_test();
   end
endmodule
